// ### bench/dgz_vme_host.sv
// Bus master model issuing single transfers to the digitizer bank
`timescale 1ns/1ps
module dgz_vme_host (
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        dtack_n_i,
	output logic      [5:0]  am_o,
	output logic      [31:1] addr_o,
	output logic             as_n_o,
	output logic             ds0_n_o,
	output logic             ds1_n_o,
	output logic             write_n_o,
	output logic      [15:0] wdata_o
);
	initial begin
		am_o = 6'h00;
		addr_o = '0;
		as_n_o = 1'b1;
		ds0_n_o = 1'b1;
		ds1_n_o = 1'b1;
		write_n_o = 1'b1;
		wdata_o = 16'h0000;
	end

	// Holds the request until acknowledge is seen, then releases on that edge
	task automatic xfer(input logic [5:0] am, input logic [31:0] a, input logic wr,
		input logic [1:0] ds, input logic [15:0] wd, output logic [15:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		rd = 16'h0000;
		@(posedge clk_i);
		am_o <= am;
		addr_o <= a[31:1];
		write_n_o <= !wr;
		wdata_o <= wd;
		as_n_o <= 1'b0;
		ds1_n_o <= !ds[1];
		ds0_n_o <= !ds[0];
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clk_i);
			if (dtack_n_i === 1'b0) begin
				ok = 1'b1;
				rd = rdata_i;
			end
		end
		as_n_o <= 1'b1;
		ds1_n_o <= 1'b1;
		ds0_n_o <= 1'b1;
		// Released lines show the inverse so stale data cannot pass
		wdata_o <= ~wd;
		for (n = 0; n < 40 && dtack_n_i !== 1'b1; n++)
			@(posedge clk_i);
		if (dtack_n_i !== 1'b1)
			ok = 1'b0;
		// Strobes stay negated long enough to be seen between cycles
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ### bench/tb.sv
// Self-checking bench: registers, sample RAM, sampling and trigger gating
`timescale 1ns/1ps
`include "dgz_consts.svh"
module tb;
	localparam logic [31:0] IOB = 32'h0000A000;
	localparam logic [31:0] MEMB = 32'h00100000;
	localparam logic [7:0]  RV [8] = '{8'h3F, 8'h1F, 8'h12, 8'h34, 8'h56, 8'h78, 8'hE4, 8'h5A};
	localparam logic [11:0] SMP [4] = '{12'h900, 12'hA01, 12'hB02, 12'hC03};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        trig = 1'b0;
	logic        gate = 1'b0;
	logic        eclk = 1'b0;
	logic        oe_last = 1'b0;
	logic [47:0] adc = 48'h0;
	logic [5:0]  am;
	logic [31:1] addr;
	logic        as_n, ds0_n, ds1_n, wr_n, oe, dtack_n, act;
	logic [15:0] wd, rdat, rv;
	logic [3:0]  conv;
	int          error_cnt = 0;
	int          compares = 0;
	int          conv_cnt = 0;
	int          conv3_cnt = 0;
	int          conv_all = 0;
	int          act_cnt = 0;

	dgz_top uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .VME_AM_I(am), .VME_ADDR_I(addr),
		.VME_AS_N_I(as_n), .VME_DS0_N_I(ds0_n), .VME_DS1_N_I(ds1_n), .VME_WRITE_N_I(wr_n),
		.VME_DATA_I(wd), .VME_DATA_O(rdat), .VME_DATA_OE_O(oe), .VME_DTACK_N_O(dtack_n),
		.MEM_BASE_SW_I(13'h0002), .IO_BASE_SW_I(8'hA0), .EXT_TRIG_I(trig),
		.EXT_GATE_I(gate), .EXT_CLK_I(eclk), .ADC_DATA_I(adc), .CONV_START_O(conv),
		.DIG_ACTIVE_O(act));
	dgz_vme_host host (.clk_i(clk), .rdata_i(rdat), .dtack_n_i(dtack_n), .am_o(am),
		.addr_o(addr), .as_n_o(as_n), .ds0_n_o(ds0_n), .ds1_n_o(ds1_n),
		.write_n_o(wr_n), .wdata_o(wd));

	initial begin
		forever #2 clk = ~clk;
	end
	// Counters only grow; scenarios take differences, so each has one writer
	always @(posedge clk) begin
		if (conv[0] === 1'b1)
			conv_cnt++;
		if (conv[3] === 1'b1)
			conv3_cnt++;
		if (conv === 4'hF)
			conv_all++;
		if (act === 1'b1)
			act_cnt++;
		if (dtack_n === 1'b0)
			oe_last = oe;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic acc(input logic [5:0] m, input logic [31:0] a, input logic w,
		input logic [1:0] ds, input logic [15:0] d);
		bit ok;
		host.xfer(m, a, w, ds, d, rv, ok);
		if (!ok) begin
			chk("bus acknowledge", 16'h0001, 16'h0000);
			give_verdict();
		end
		chk("data enable", {15'h0, !w}, {15'h0, oe_last});
	endtask
	// Registers only ever see single-byte cycles on their own lane
	task automatic wreg(input logic [7:0] off, input logic [7:0] v);
		acc(`DGZ_AM_A16_DATA, IOB + {24'h0, off}, 1'b1, off[0] ? 2'b01 : 2'b10, {v, v});
	endtask
	task automatic creg(input logic [7:0] off, input logic [7:0] e);
		acc(`DGZ_AM_A16_DATA, IOB + {24'h0, off}, 1'b0, off[0] ? 2'b01 : 2'b10, 16'h0);
		chk("register", {8'h00, e}, {8'h00, off[0] ? rv[7:0] : rv[15:8]});
	endtask
	task automatic wmem(input logic [31:0] a, input logic [1:0] ds, input logic [15:0] d);
		acc(`DGZ_AM_A24_DATA, MEMB + a, 1'b1, ds, d);
	endtask
	task automatic cmem(input logic [31:0] a, input logic [15:0] e);
		acc(`DGZ_AM_A24_DATA, MEMB + a, 1'b0, 2'b11, 16'h0);
		chk("ram word", e, rv);
	endtask
	task automatic pulse_trig();
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		trig <= 1'b0;
		repeat (60) @(posedge clk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 8; i++)
			creg(8'(i), 8'h00);
		chk("active output", 16'h0, {15'h0, act});
	endtask
	task automatic t_regs();
		for (int i = 0; i < 8; i++)
			wreg(8'(i), RV[i]);
		for (int i = 0; i < 8; i++)
			creg(8'(i), RV[i]);
		wreg(8'h08, 8'hFF);
		creg(8'h08, 8'h00);
		for (int i = 0; i < 8; i++)
			wreg(8'(i), 8'h00);
	endtask
	task automatic t_mem();
		for (int b = 0; b < 4; b++)
			wmem(32'(b) * 32'h20000 + 32'h1FFFE, 2'b11, 16'h0A50);
		// Upper lane carries junk that a byte write must not store
		for (int b = 0; b < 4; b++)
			wmem(32'(b) * 32'h20000 + 32'h1FFFE, 2'b01, {8'hFF, 8'hC0 + 8'(b)});
		for (int b = 0; b < 4; b++)
			cmem(32'(b) * 32'h20000 + 32'h1FFFE, {8'h0A, 8'hC0 + 8'(b)});
	endtask
	task automatic eclk_edges(input int n);
		repeat (n) begin
			eclk <= 1'b1;
			repeat (4) @(posedge clk);
			eclk <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic t_sample();
		int c0, f0, a0;
		for (int c = 0; c < 4; c++)
			wmem(32'(c) * 32'h20000 + 32'h6, 2'b11, 16'h0EEE);
		adc <= {SMP[3], SMP[2], SMP[1], SMP[0]};
		wreg(`DGZ_OFF_PTC_LOW, 8'h03);
		wreg(`DGZ_OFF_CSR_LOW, 8'h01);
		wreg(`DGZ_OFF_CSR_HIGH, 8'h40);
		c0 = conv_cnt;
		f0 = conv_all;
		a0 = act_cnt;
		wreg(`DGZ_OFF_CSR_LOW, 8'h81);
		repeat (80) @(posedge clk);
		chk("active seen", 16'h1, {15'h0, act_cnt != a0});
		chk("active after count", 16'h0, {15'h0, act});
		chk("convert pulses", 16'd3, 16'(conv_cnt - c0));
		chk("joint convert pulses", 16'd3, 16'(conv_all - f0));
		for (int c = 0; c < 4; c++)
			for (int w = 0; w < 4; w++)
				cmem(32'(c) * 32'h20000 + 32'(w * 2), w < 3 ? {4'h0, SMP[c]} : 16'h0EEE);
		creg(`DGZ_OFF_LOC_LOW, 8'h03);
		wreg(`DGZ_OFF_LOC_LOW, 8'h55);
		creg(`DGZ_OFF_LOC_LOW, 8'h03);
		creg(`DGZ_OFF_CSR_HIGH, 8'h40);
		creg(`DGZ_OFF_CSR_LOW, 8'h01);
	endtask
	task automatic t_ext();
		int c0, a0;
		a0 = act_cnt;
		pulse_trig();
		chk("active, trigger input off", 16'h0, {15'h0, act_cnt != a0});
		wreg(`DGZ_OFF_CSR_HIGH, 8'h44);
		c0 = conv_cnt;
		a0 = act_cnt;
		pulse_trig();
		chk("active, trigger input on", 16'h1, {15'h0, act_cnt != a0});
		chk("convert pulses", 16'd3, 16'(conv_cnt - c0));
		creg(`DGZ_OFF_LOC_LOW, 8'h06);
		wreg(`DGZ_OFF_CSR_HIGH, 8'h00);
		creg(`DGZ_OFF_CSR_HIGH, 8'h00);
		wreg(`DGZ_OFF_LOC_LOW, 8'h20);
		creg(`DGZ_OFF_LOC_LOW, 8'h20);
	endtask
	// Two gates; only the first may re-zero the pointer, the second appends
	task automatic t_gate();
		int c0, a0;
		wreg(`DGZ_OFF_CSR_HIGH, 8'h4A);
		c0 = conv_cnt;
		a0 = act_cnt;
		repeat (2) begin
			gate <= 1'b1;
			repeat (24) @(posedge clk);
			gate <= 1'b0;
			repeat (12) @(posedge clk);
		end
		chk("active seen, gate", 16'h1, {15'h0, act_cnt != a0});
		chk("active after gate", 16'h0, {15'h0, act});
		chk("gate pulses present", 16'h1, {15'h0, conv_cnt != c0});
		creg(`DGZ_OFF_LOC_HIGH, 8'h00);
		creg(`DGZ_OFF_LOC_LOW, 8'(conv_cnt - c0));
		wreg(`DGZ_OFF_CSR_HIGH, 8'h00);
	endtask
	// External master clock, rate code 2, staggered skew on every channel
	task automatic t_eclk();
		int c0, c3, f0;
		wreg(`DGZ_OFF_LOC_LOW, 8'h40);
		wreg(`DGZ_OFF_PTC_LOW, 8'h02);
		wreg(`DGZ_OFF_CHANNEL_SKEW, 8'hE4);
		wreg(`DGZ_OFF_CSR_LOW, 8'h12);
		wreg(`DGZ_OFF_CSR_HIGH, 8'h41);
		c0 = conv_cnt;
		c3 = conv3_cnt;
		f0 = conv_all;
		wreg(`DGZ_OFF_CSR_LOW, 8'h92);
		eclk_edges(3);
		repeat (8) @(posedge clk);
		chk("pulses after three edges", 16'd1, 16'(conv_cnt - c0));
		eclk_edges(5);
		repeat (8) @(posedge clk);
		chk("skewed ch0 pulses", 16'd2, 16'(conv_cnt - c0));
		chk("skewed ch3 pulses", 16'd2, 16'(conv3_cnt - c3));
		chk("joint pulses, skewed", 16'd0, 16'(conv_all - f0));
		chk("active after skewed run", 16'h0, {15'h0, act});
		creg(`DGZ_OFF_LOC_LOW, 8'h42);
		for (int c = 0; c < 4; c++)
			for (int w = 0; w < 2; w++)
				cmem(32'(c) * 32'h20000 + 32'h80 + 32'(w * 2), {4'h0, SMP[c]});
		wreg(`DGZ_OFF_CSR_HIGH, 8'h00);
	endtask
	// Circular run from near the top; wrap must carry the pointer past zero
	task automatic t_circ();
		int c0;
		wreg(`DGZ_OFF_LOC_HIGH, 8'hFF);
		wreg(`DGZ_OFF_LOC_LOW, 8'hFE);
		wreg(`DGZ_OFF_PTC_LOW, 8'h04);
		wreg(`DGZ_OFF_CSR_LOW, 8'h01);
		wreg(`DGZ_OFF_CSR_HIGH, 8'h70);
		repeat (30) @(posedge clk);
		chk("active, circular", 16'h1, {15'h0, act});
		wreg(`DGZ_OFF_CSR_LOW, 8'h81);
		repeat (40) @(posedge clk);
		chk("active after circular stop", 16'h0, {15'h0, act});
		c0 = conv_cnt;
		repeat (20) @(posedge clk);
		chk("pulses after halt", 16'd0, 16'(conv_cnt - c0));
		creg(`DGZ_OFF_LOC_HIGH, 8'h00);
		creg(`DGZ_OFF_CSR_HIGH, 8'h70);
		wreg(`DGZ_OFF_CSR_HIGH, 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_regs();
		t_mem();
		t_sample();
		t_ext();
		t_gate();
		t_eclk();
		t_circ();
		give_verdict();
	end
endmodule

// ### rtl/dgz_consts.svh
// Address map, field positions, reset values and counts of the digitizer bank
`ifndef DGZ_CONSTS_SVH
`define DGZ_CONSTS_SVH

// Address modifiers accepted (data and program forms of each space)
`define DGZ_AM_A32_DATA       6'h09
`define DGZ_AM_A32_PROG       6'h0D
`define DGZ_AM_A24_DATA       6'h39
`define DGZ_AM_A24_PROG       6'h3D
`define DGZ_AM_A16_DATA       6'h29
`define DGZ_AM_A16_PROG       6'h2D

// Register byte offsets in the short I/O window
`define DGZ_OFF_CSR_HIGH      8'h00
`define DGZ_OFF_CSR_LOW       8'h01
`define DGZ_OFF_LOC_HIGH      8'h02
`define DGZ_OFF_LOC_LOW       8'h03
`define DGZ_OFF_PTC_HIGH      8'h04
`define DGZ_OFF_PTC_LOW       8'h05
`define DGZ_OFF_CHANNEL_SKEW  8'h06
`define DGZ_OFF_AUX_MODE      8'h07
`define DGZ_OFF_LANE_ODD      8'h01

// control_status_high fields
`define DGZ_CSRH_ARM          6
`define DGZ_CSRH_CIRCULAR     5
`define DGZ_CSRH_WRAP         4
`define DGZ_CSRH_AUTO_RESET   3
`define DGZ_CSRH_EXT_TRIG     2
`define DGZ_CSRH_EXT_GATE     1
`define DGZ_CSRH_EXT_CLOCK    0

// control_status_low fields
`define DGZ_CSRL_SW_TRIG      7
`define DGZ_CSRL_DESKEW       4

// Reset values
`define DGZ_RST_BYTE          8'h00
`define DGZ_RST_WORD          16'h0000

// Sample storage
`define DGZ_CHANNELS          4
`define DGZ_BANK_WORDS        65536
`define DGZ_SAMPLE_BITS       12
`define DGZ_SAMPLE_PAD        4'h0
`define DGZ_LOC_MAX           16'hFFFF

// On-board clock is divided by four before the rate divider
`define DGZ_ONBOARD_LAST      2'h3
`define DGZ_SKEW_LAST         3'h4

// Sample FIFO
`define DGZ_FIFO_DEPTH        16
`define DGZ_FIFO_WIDTH        64

`endif

// ### rtl/dgz_pkg.sv
// Types of the digitizer register bank; its sample FIFO defines its own state type
package dgz_pkg;

	typedef enum logic {BUS_IDLE, BUS_ACK} dgz_bus_t;

	typedef struct packed {
		logic [5:0]  am;
		logic [31:1] addr;
		logic        as_n;
		logic        ds1_n;
		logic        ds0_n;
		logic        write_n;
		logic [15:0] data;
		logic [12:0] mem_base;
		logic [7:0]  io_base;
		logic        ext_trig;
		logic        ext_gate;
		logic        ext_clk;
		logic [47:0] adc;
	} dgz_pins_t;

	typedef struct packed {
		dgz_pins_t   sync1;
		dgz_pins_t   sync2;
		dgz_bus_t    bus;
		logic        dtack_n;
		logic [15:0] dout;
		logic        d_oe;
		logic [6:0]  control_status_high;
		logic [4:0]  control_status_low;
		logic [15:0] loc;
		logic [15:0] ptc;
		logic [7:0]  channel_skew_delay;
		logic [7:0]  auxiliary_mode_control;
		logic        active;
		logic        counting;
		logic        halted;
		logic        auto_used;
		logic [15:0] remain;
		logic [1:0]  mdiv;
		logic        ext_clk_d;
		logic        ext_trig_d;
		logic        gate_d;
		logic [15:0] div_cnt;
		logic [2:0]  sk;
		logic [47:0] lat;
		logic [3:0]  conv;
		logic        push;
	} dgz_state_t;

endpackage

// ### rtl/dgz_top.sv
// Digitizer bus slave, control registers, sample sequencer, FIFO and sample RAM
`timescale 1ns/1ps
`include "dgz_consts.svh"

module dgz_fifo #(
	parameter int WIDTH = `DGZ_FIFO_WIDTH,
	parameter int DEPTH = `DGZ_FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} dgz_fifo_st_t;

	dgz_fifo_st_t s_r;
	dgz_fifo_st_t s_nxt;
	logic         full;
	logic         empty;

	always_comb begin
		s_nxt = s_r;
		// Extra pointer bit tells full from empty
		full = (s_r.wp ^ s_r.rp) == {1'h1, {AW{1'h0}}};
		empty = s_r.wp == s_r.rp;
		in_ready_o = !full;
		out_valid_o = !empty;
		out_data_o = s_r.mem[s_r.rp[AW-1:0]];
		if (in_valid_i && !full) begin
			s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
			s_nxt.wp = s_r.wp + 1'h1;
		end
		if (out_ready_i && !empty) begin
			s_nxt.rp = s_r.rp + 1'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

module dgz_top
	import dgz_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic [5:0]  VME_AM_I,
	input  wire logic [31:1] VME_ADDR_I,
	input  wire logic        VME_AS_N_I,
	input  wire logic        VME_DS0_N_I,
	input  wire logic        VME_DS1_N_I,
	input  wire logic        VME_WRITE_N_I,
	input  wire logic [15:0] VME_DATA_I,
	output logic      [15:0] VME_DATA_O,
	output logic             VME_DATA_OE_O,
	output logic             VME_DTACK_N_O,
	input  wire logic [12:0] MEM_BASE_SW_I,
	input  wire logic [7:0]  IO_BASE_SW_I,
	input  wire logic        EXT_TRIG_I,
	input  wire logic        EXT_GATE_I,
	input  wire logic        EXT_CLK_I,
	input  wire logic [47:0] ADC_DATA_I,
	output logic      [3:0]  CONV_START_O,
	output logic             DIG_ACTIVE_O
);
	dgz_state_t  s_r;
	dgz_state_t  s_nxt;
	dgz_pins_t   pins;
	dgz_pins_t   p;
	logic [15:0] mem [0:`DGZ_CHANNELS-1][0:`DGZ_BANK_WORDS-1];
	logic        strobe;
	logic        hit_mem;
	logic        hit_io;
	logic        take;
	logic [1:0]  bank;
	logic [15:0] idx;
	logic [7:0]  off_hi;
	logic [15:0] mem_rd;
	logic        host_we;
	logic        sw_trig;
	logic        trig;
	logic        gate_rise;
	logic        tick;
	logic        mtick;
	logic        acc;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        drain;
	logic [63:0] fifo_out;
	logic        armed;

	function automatic logic [7:0] reg_rd(input dgz_state_t st, input logic [7:0] off);
		case (off)
			`DGZ_OFF_CSR_HIGH:     reg_rd = {st.active, st.control_status_high};
			`DGZ_OFF_CSR_LOW:      reg_rd = {3'h0, st.control_status_low};
			`DGZ_OFF_LOC_HIGH:     reg_rd = st.loc[15:8];
			`DGZ_OFF_LOC_LOW:      reg_rd = st.loc[7:0];
			`DGZ_OFF_PTC_HIGH:     reg_rd = st.ptc[15:8];
			`DGZ_OFF_PTC_LOW:      reg_rd = st.ptc[7:0];
			`DGZ_OFF_CHANNEL_SKEW: reg_rd = st.channel_skew_delay;
			`DGZ_OFF_AUX_MODE:     reg_rd = st.auxiliary_mode_control;
			default:               reg_rd = `DGZ_RST_BYTE;
		endcase
	endfunction

	function automatic dgz_state_t reg_wr(input dgz_state_t st, input logic [7:0] off,
		input logic [7:0] v);
		reg_wr = st;
		case (off)
			`DGZ_OFF_CSR_HIGH:     reg_wr.control_status_high = v[6:0];
			`DGZ_OFF_CSR_LOW:      reg_wr.control_status_low = v[4:0];
			`DGZ_OFF_LOC_HIGH: begin
				if (!st.control_status_high[`DGZ_CSRH_ARM]) begin
					reg_wr.loc[15:8] = v;
				end
			end
			`DGZ_OFF_LOC_LOW: begin
				if (!st.control_status_high[`DGZ_CSRH_ARM]) begin
					reg_wr.loc[7:0] = v;
				end
			end
			`DGZ_OFF_PTC_HIGH:     reg_wr.ptc[15:8] = v;
			`DGZ_OFF_PTC_LOW:      reg_wr.ptc[7:0] = v;
			`DGZ_OFF_CHANNEL_SKEW: reg_wr.channel_skew_delay = v;
			`DGZ_OFF_AUX_MODE:     reg_wr.auxiliary_mode_control = v;
			default: ;
		endcase
	endfunction

	// Next location: saturate at the top unless wrap is on
	function automatic logic [15:0] loc_adv(input logic [15:0] loc, input logic wrap);
		if (loc == `DGZ_LOC_MAX) begin
			loc_adv = wrap ? `DGZ_RST_WORD : loc;
		end else begin
			loc_adv = loc + 16'h1;
		end
	endfunction

	function automatic logic [15:0] div_last(input logic [3:0] r);
		div_last = (16'h1 << (r - 4'h1)) - 16'h1;
	endfunction

	assign pins = {VME_AM_I, VME_ADDR_I, VME_AS_N_I, VME_DS1_N_I, VME_DS0_N_I, VME_WRITE_N_I,
		VME_DATA_I, MEM_BASE_SW_I, IO_BASE_SW_I, EXT_TRIG_I, EXT_GATE_I, EXT_CLK_I, ADC_DATA_I};

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		p = s_r.sync2;
		armed = s_r.control_status_high[`DGZ_CSRH_ARM];
		strobe = !p.as_n && (!p.ds0_n || !p.ds1_n);
		hit_mem = ((p.am == `DGZ_AM_A32_DATA || p.am == `DGZ_AM_A32_PROG)
			&& p.addr[31:19] == p.mem_base)
			|| ((p.am == `DGZ_AM_A24_DATA || p.am == `DGZ_AM_A24_PROG)
			&& p.addr[23:19] == p.mem_base[4:0]);
		hit_io = (p.am == `DGZ_AM_A16_DATA || p.am == `DGZ_AM_A16_PROG)
			&& p.addr[15:8] == p.io_base;
		take = s_r.bus == BUS_IDLE && strobe && (hit_mem || hit_io);
		bank = p.addr[18:17];
		idx = p.addr[16:1];
		off_hi = {p.addr[7:1], 1'h0};
		mem_rd = mem[bank][idx];
		host_we = take && hit_mem && !p.write_n;
		sw_trig = take && hit_io && !p.write_n && !p.ds0_n
			&& off_hi == `DGZ_OFF_CSR_HIGH && p.data[`DGZ_CSRL_SW_TRIG];

		case (s_r.bus)
			BUS_IDLE: begin
				if (take) begin
					s_nxt.bus = BUS_ACK;
					s_nxt.dtack_n = 1'h0;
					s_nxt.d_oe = p.write_n;
					if (hit_mem) begin
						s_nxt.dout = mem_rd;
					end else begin
						// Even offset on the upper lane, odd on the lower
						s_nxt.dout = {reg_rd(s_r, off_hi),
							reg_rd(s_r, off_hi | `DGZ_OFF_LANE_ODD)};
						if (!p.write_n && !p.ds1_n) begin
							s_nxt = reg_wr(s_nxt, off_hi, p.data[15:8]);
						end
						if (!p.write_n && !p.ds0_n) begin
							s_nxt = reg_wr(s_nxt, off_hi | `DGZ_OFF_LANE_ODD,
								p.data[7:0]);
						end
					end
				end
			end
			BUS_ACK: begin
				if (!strobe) begin
					s_nxt.bus = BUS_IDLE;
					s_nxt.dtack_n = 1'h1;
					s_nxt.d_oe = 1'h0;
				end
			end
			default: s_nxt.bus = BUS_IDLE;
		endcase

		// Trigger sources
		s_nxt.ext_trig_d = p.ext_trig;
		s_nxt.gate_d = p.ext_gate;
		s_nxt.ext_clk_d = p.ext_clk;
		trig = armed && ((s_r.control_status_high[`DGZ_CSRH_EXT_TRIG] && p.ext_trig && !s_r.ext_trig_d)
			|| (sw_trig && !s_r.control_status_high[`DGZ_CSRH_EXT_TRIG]));
		gate_rise = armed && s_r.control_status_high[`DGZ_CSRH_EXT_GATE] && p.ext_gate && !s_r.gate_d;

		// Master clock and rate divider
		s_nxt.mdiv = s_r.mdiv + 2'h1;
		mtick = s_r.control_status_high[`DGZ_CSRH_EXT_CLOCK] ? (p.ext_clk && !s_r.ext_clk_d)
			: (s_r.mdiv == `DGZ_ONBOARD_LAST);
		tick = 1'h0;
		if (!s_r.active || s_r.control_status_low[3:0] == 4'h0) begin
			s_nxt.div_cnt = `DGZ_RST_WORD;
		end else if (mtick) begin
			if (s_r.div_cnt >= div_last(s_r.control_status_low[3:0])) begin
				tick = 1'h1;
				s_nxt.div_cnt = `DGZ_RST_WORD;
			end else begin
				s_nxt.div_cnt = s_r.div_cnt + 16'h1;
			end
		end

		// Conversion start, optionally skewed per channel
		s_nxt.conv = 4'h0;
		if (tick && !s_r.push && s_r.sk == 3'h0) begin
			if (!s_r.control_status_low[`DGZ_CSRL_DESKEW]) begin
				s_nxt.lat = p.adc;
				s_nxt.conv = 4'hF;
				s_nxt.push = 1'h1;
			end else begin
				s_nxt.sk = 3'h1;
			end
		end
		if (s_r.sk != 3'h0) begin
			for (int c = 0; c < `DGZ_CHANNELS; c++) begin
				if (s_r.sk == 3'(s_r.channel_skew_delay[2*c +: 2]) + 3'h1) begin
					s_nxt.lat[12*c +: 12] = p.adc[12*c +: 12];
					s_nxt.conv[c] = 1'h1;
				end
			end
			if (s_r.sk == `DGZ_SKEW_LAST) begin
				s_nxt.sk = 3'h0;
				s_nxt.push = 1'h1;
			end else begin
				s_nxt.sk = s_r.sk + 3'h1;
			end
		end

		// A sample counts only once the FIFO takes it
		acc = s_r.push && fifo_in_ready;
		if (acc) begin
			s_nxt.push = 1'h0;
		end

		if (!armed) begin
			s_nxt.active = 1'h0;
			s_nxt.counting = 1'h0;
			s_nxt.halted = 1'h0;
			s_nxt.auto_used = 1'h0;
		end else if (s_r.control_status_high[`DGZ_CSRH_EXT_GATE]) begin
			if (acc) begin
				s_nxt.loc = loc_adv(s_r.loc, s_r.control_status_high[`DGZ_CSRH_WRAP]);
			end
			if (gate_rise) begin
				s_nxt.active = 1'h1;
				// Only the first gate of an arming may re-zero the pointer
				if (s_r.control_status_high[`DGZ_CSRH_AUTO_RESET] && !s_r.auto_used) begin
					s_nxt.loc = `DGZ_RST_WORD;
					s_nxt.auto_used = 1'h1;
				end
			end
			if (!p.ext_gate && s_r.gate_d) begin
				s_nxt.active = 1'h0;
			end
		end else if (s_r.control_status_high[`DGZ_CSRH_CIRCULAR]) begin
			if (!s_r.halted) begin
				s_nxt.active = 1'h1;
			end
			if (acc) begin
				s_nxt.loc = loc_adv(s_r.loc, s_r.control_status_high[`DGZ_CSRH_WRAP]);
				if (s_r.counting) begin
					s_nxt.remain = s_r.remain - 16'h1;
					if (s_r.remain <= 16'h1) begin
						s_nxt.counting = 1'h0;
						s_nxt.halted = 1'h1;
						s_nxt.active = 1'h0;
					end
				end
			end
			if (trig && !s_r.counting && !s_r.halted) begin
				s_nxt.counting = 1'h1;
				s_nxt.remain = s_r.ptc;
			end
		end else begin
			if (acc) begin
				s_nxt.loc = loc_adv(s_r.loc, s_r.control_status_high[`DGZ_CSRH_WRAP]);
				if (s_r.loc == `DGZ_LOC_MAX && !s_r.control_status_high[`DGZ_CSRH_WRAP]) begin
					s_nxt.halted = 1'h1;
					s_nxt.active = 1'h0;
				end
				s_nxt.remain = s_r.remain - 16'h1;
				if (s_r.remain <= 16'h1) begin
					s_nxt.active = 1'h0;
				end
			end
			// A new trigger restarts the run in progress with a full count
			if (trig && !s_r.halted) begin
				if (s_r.control_status_high[`DGZ_CSRH_AUTO_RESET]) begin
					s_nxt.loc = `DGZ_RST_WORD;
				end
				s_nxt.remain = s_r.ptc;
				s_nxt.active = s_r.ptc != `DGZ_RST_WORD;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s_r <= '0;
			s_r.dtack_n <= 1'h1;
			s_r.sync1.as_n <= 1'h1;
			s_r.sync2.as_n <= 1'h1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Host writes win the RAM port; the FIFO absorbs the stall
	assign drain = fifo_out_valid && !host_we;

	dgz_fifo #(
		.WIDTH (`DGZ_FIFO_WIDTH),
		.DEPTH (`DGZ_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_SYS_I),
		.rst_n_i     (RST_N_I),
		.in_valid_i  (s_r.push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({s_r.loc, s_r.lat}),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!host_we),
		.out_data_o  (fifo_out)
	);

	always_ff @(posedge CLK_SYS_I) begin
		if (host_we) begin
			if (!p.ds1_n) begin
				mem[bank][idx][15:8] <= p.data[15:8];
			end
			if (!p.ds0_n) begin
				mem[bank][idx][7:0] <= p.data[7:0];
			end
		end else if (drain) begin
			for (int c = 0; c < `DGZ_CHANNELS; c++) begin
				mem[c][fifo_out[63:48]] <= {`DGZ_SAMPLE_PAD,
					fifo_out[12*c +: 12]};
			end
		end
	end

	assign VME_DATA_O = s_r.dout;
	assign VME_DATA_OE_O = s_r.d_oe;
	assign VME_DTACK_N_O = s_r.dtack_n;
	assign CONV_START_O = s_r.conv;
	assign DIG_ACTIVE_O = s_r.active;

	logic seen_r;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seen_r <= 1'h0;
		end else begin
			seen_r <= 1'h1;
		end
	end

	default clocking dgz_cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_cycle_taken;
		take;
	endsequence
	sequence s_acked_until_release;
		!VME_DTACK_N_O ##1 !VME_DTACK_N_O;
	endsequence

	a_bus_ack: assert property (
		s_cycle_taken ##1 strobe |-> s_acked_until_release)
		else $error("bus cycle not acknowledged");
	a_bus_release: assert property (
		(!VME_DTACK_N_O && !strobe) |=> VME_DTACK_N_O && !VME_DATA_OE_O)
		else $error("acknowledge held after strobe release");
	a_mem_read: assert property (
		take && hit_mem && p.write_n |=> VME_DATA_O == $past(mem_rd) && VME_DATA_OE_O)
		else $error("memory read data wrong");
	a_reg_decode: assert property (
		take && hit_io && p.write_n && off_hi == `DGZ_OFF_CHANNEL_SKEW
		|=> VME_DATA_O[15:8] == $past(s_r.channel_skew_delay) && VME_DATA_O[7:0] == $past(s_r.auxiliary_mode_control))
		else $error("register decode wrong");
	a_disarm_stop: assert property (
		!armed |=> !DIG_ACTIVE_O)
		else $error("active while disarmed");
	a_loc_locked: assert property (
		armed && !acc && !trig && !gate_rise |=> $stable(s_r.loc))
		else $error("location pointer moved while armed");
	a_loc_step: assert property (
		acc && armed && !trig && !gate_rise && s_r.loc != `DGZ_LOC_MAX
		|=> s_r.loc == $past(s_r.loc) + 16'h1)
		else $error("location pointer did not advance");
	a_wrap_stop: assert property (
		acc && armed && !trig && s_r.loc == `DGZ_LOC_MAX && !s_r.control_status_high[`DGZ_CSRH_WRAP]
		&& !s_r.control_status_high[`DGZ_CSRH_CIRCULAR] && !s_r.control_status_high[`DGZ_CSRH_EXT_GATE]
		|=> !DIG_ACTIVE_O [*2])
		else $error("run continued past end of memory");
	a_sw_trigger: assert property (
		sw_trig && armed && s_r.control_status_high[5:1] == 5'h00 && !s_r.halted
		&& s_r.ptc != `DGZ_RST_WORD |=> DIG_ACTIVE_O && s_r.remain == $past(s_r.ptc))
		else $error("software trigger did not start a run");
	a_rate_off: assert property (
		s_r.control_status_low[3:0] == 4'h0 |-> !tick)
		else $error("sample tick with rate code zero");
	a_pad_zero: assert property (
		drain |=> mem[1][$past(fifo_out[63:48])][15:12] == `DGZ_SAMPLE_PAD)
		else $error("sample padding not zero");
	a_reset_clear: assert property (
		!seen_r |-> s_r.control_status_high == 7'h00 && s_r.control_status_low == 5'h00 && !DIG_ACTIVE_O)
		else $error("control bits not cleared by reset");
endmodule
